// File: rtl/t1rad_top.sv
`timescale 1ns/1ps
`include "t1rad_regs.svh"
// What this block does
// - Set blue alarm when a 3 ms window holds five or fewer zeros.
// - Clear blue alarm when a 3 ms window holds six or more zeros.
// - D4 bit-2 mode: yellow set when at least 254 of 256 bit-2 samples are zero.
// - D4 bit-2 mode: yellow clears when fewer than 254 of 256 are zero.
// - Twelfth F-bit mode: yellow set after two consecutive ones in that bit.
// - Twelfth F-bit mode: yellow clears after two consecutive zeros in that bit.
// - ESF mode: yellow set after sixteen consecutive 00FF data-link patterns.
// - ESF mode: yellow clears when at most fourteen of sixteen patterns match.
// - Set red alarm after 192 consecutive received zeros.
// - Clear red alarm on fourteen ones within 112 bits from the first one.
// - Red alarm is reported through the carrier-loss flag.
// - Blue detection tolerates bit errors and ignores framed all-ones.
module t1rad_top
	import t1rad_pkg::*;
#(
	parameter int BLUE_WINDOW_CYCLES = `T1RAD_BLUE_WINDOW_CYC,
	parameter int ADDR_W             = 8
) (
	input  wire logic              REF_CLK_I,
	input  wire logic              RESET_N_I,
	input  wire logic              RX_DATA_I,
	input  wire logic              RX_BIT_STROBE_I,
	input  wire logic              RX_CH_BIT2_I,
	input  wire logic              RX_FBIT12_I,
	input  wire logic              RX_FACILITY_DATA_LINK_I,
	input  wire logic              RX_SYNC_I,
	input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
	input  wire logic              S_AXI_AWVALID_I,
	output logic                   S_AXI_AWREADY_O,
	input  wire logic [31:0]       S_AXI_WDATA_I,
	input  wire logic [3:0]        S_AXI_WSTRB_I,
	input  wire logic              S_AXI_WVALID_I,
	output logic                   S_AXI_WREADY_O,
	output logic [1:0]             S_AXI_BRESP_O,
	output logic                   S_AXI_BVALID_O,
	input  wire logic              S_AXI_BREADY_I,
	input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
	input  wire logic              S_AXI_ARVALID_I,
	output logic                   S_AXI_ARREADY_O,
	output logic [31:0]            S_AXI_RDATA_O,
	output logic [1:0]             S_AXI_RRESP_O,
	output logic                   S_AXI_RVALID_O,
	input  wire logic              S_AXI_RREADY_I,
	output logic                   IRQ_O
);

	localparam int BW = $clog2(BLUE_WINDOW_CYCLES + 1);
	localparam int FW = `T1RAD_FLAG_WIDTH;

	t1rad_rx_type        rx_meta_q;
	t1rad_rx_type        rx_sync_q;
	logic                strobe_last_q;
	logic                bit_ev;
	logic                rx_bit;

	logic [1:0]          ctl_q;
	logic [FW-1:0]       enable_q;
	logic [FW-1:0]       event_q;
	logic [FW-1:0]       clear_pulse;
	t1rad_flags_type     flags;
	t1rad_flags_type     flags_last_q;

	logic [BW-1:0]       blue_cyc_q;
	logic [2:0]          blue_zeros_q;
	logic                blue_q;

	logic [8:0]          d4_count_q;
	logic [8:0]          d4_zeros_q;
	logic                d4_yellow_q;
	logic                f12_last_q;
	logic                f12_seen_q;
	logic                f12_yellow_q;

	logic [15:0]         link_shift_q;
	logic [3:0]          link_count_q;
	logic [15:0]         esf_hist_q;
	logic                esf_yellow_q;
	logic [15:0]         link_word;

	t1rad_red_state_type red_state_q;
	logic [7:0]          red_zeros_q;
	logic [6:0]          red_pos_q;
	logic [3:0]          red_ones_q;

	logic                aw_have_q;
	logic [ADDR_W-1:0]   aw_addr_q;
	logic                w_have_q;
	logic [31:0]         w_data_q;
	logic [3:0]          w_strb_q;
	logic                bvalid_q;
	logic [1:0]          bresp_q;
	logic                rvalid_q;
	logic [31:0]         rdata_q;
	logic [1:0]          rresp_q;
	logic                wr_fire;

	// Every receive pin passes two flops; the strobe edge is taken after the second.
	always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			rx_meta_q     <= '0;
			rx_sync_q     <= '0;
			strobe_last_q <= 1'b0;
		end else begin
			rx_meta_q     <= '{data: RX_DATA_I, strobe: RX_BIT_STROBE_I,
				ch_bit2: RX_CH_BIT2_I, fbit12: RX_FBIT12_I,
				facility_data_link: RX_FACILITY_DATA_LINK_I, sync: RX_SYNC_I};
			rx_sync_q     <= rx_meta_q;
			strobe_last_q <= rx_sync_q.strobe;
		end
	end

	assign bit_ev = rx_sync_q.strobe & ~strobe_last_q;
	assign rx_bit = rx_sync_q.data;

	// Blue alarm: zeros counted over a fixed window of clock cycles. A framed
	// all-ones stream carries framing zeros, which keeps it above the limit.
	always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			blue_cyc_q   <= '0;
			blue_zeros_q <= 3'h0;
			blue_q       <= 1'b0;
		end else if (blue_cyc_q == BW'(BLUE_WINDOW_CYCLES - 1)) begin
			blue_cyc_q   <= '0;
			blue_zeros_q <= 3'h0;
			if ((blue_zeros_q + 3'(bit_ev & ~rx_bit)) <= 3'(`T1RAD_BLUE_MAX_ZEROS)) begin
				blue_q <= 1'b1;
			end else begin
				blue_q <= 1'b0;
			end
		end else begin
			blue_cyc_q <= blue_cyc_q + BW'(1);
			if (bit_ev && !rx_bit && blue_zeros_q != 3'(`T1RAD_BLUE_CLR_ZEROS)) begin
				blue_zeros_q <= blue_zeros_q + 3'h1;
			end
		end
	end

	// D4 bit-2 yellow: judged on consecutive blocks of 256 channel samples.
	// The zero is widened by concatenation, since a cast would invert the padding too.
	always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			d4_count_q  <= 9'h000;
			d4_zeros_q  <= 9'h000;
			d4_yellow_q <= 1'b0;
		end else if (bit_ev && rx_sync_q.ch_bit2) begin
			if (d4_count_q == 9'(`T1RAD_D4_GROUP - 1)) begin
				d4_count_q  <= 9'h000;
				d4_zeros_q  <= 9'h000;
				d4_yellow_q <= (d4_zeros_q + {8'h00, ~rx_bit}) >= 9'(`T1RAD_D4_SET_ZEROS);
			end else begin
				d4_count_q <= d4_count_q + 9'h001;
				d4_zeros_q <= d4_zeros_q + {8'h00, ~rx_bit};
			end
		end
	end

	// Twelfth F-bit yellow: two equal samples in a row change the state.
	always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			f12_last_q   <= 1'b0;
			f12_seen_q   <= 1'b0;
			f12_yellow_q <= 1'b0;
		end else if (bit_ev && rx_sync_q.fbit12) begin
			f12_last_q <= rx_bit;
			f12_seen_q <= 1'b1;
			if (f12_seen_q && f12_last_q && rx_bit) begin
				f12_yellow_q <= 1'b1;
			end else if (f12_seen_q && !f12_last_q && !rx_bit) begin
				f12_yellow_q <= 1'b0;
			end
		end
	end

	// ESF yellow: data-link bits form 16-bit words, history of word matches.
	// Word alignment is taken from the first data-link bit after reset.
	assign link_word = {link_shift_q[14:0], rx_bit};

	always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			link_shift_q <= 16'h0000;
			link_count_q <= 4'h0;
			esf_hist_q   <= 16'h0000;
			esf_yellow_q <= 1'b0;
		end else if (bit_ev && rx_sync_q.facility_data_link) begin
			link_shift_q <= link_word;
			link_count_q <= link_count_q + 4'h1;
			if (link_count_q == 4'hF) begin
				esf_hist_q <= {esf_hist_q[14:0], link_word == `T1RAD_ESF_PATTERN};
				if (&{esf_hist_q[14:0], link_word == `T1RAD_ESF_PATTERN}) begin
					esf_yellow_q <= 1'b1;
				end else if ($countones({esf_hist_q[14:0], link_word == `T1RAD_ESF_PATTERN})
					<= `T1RAD_ESF_CLR_MAX) begin
					esf_yellow_q <= 1'b0;
				end
			end
		end
	end

	// Red alarm: zero run to declare, then a ones count from the first one.
	always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			red_state_q <= RED_CLEAR;
			red_zeros_q <= 8'h00;
			red_pos_q   <= 7'h00;
			red_ones_q  <= 4'h0;
		end else if (bit_ev) begin
			case (red_state_q)
				RED_CLEAR: begin
					if (rx_bit) begin
						red_zeros_q <= 8'h00;
					end else if (red_zeros_q == 8'(`T1RAD_RED_SET_ZEROS - 1)) begin
						red_zeros_q <= 8'h00;
						red_state_q <= RED_ALARM;
					end else begin
						red_zeros_q <= red_zeros_q + 8'h01;
					end
				end
				RED_ALARM: begin
					if (rx_bit) begin
						red_pos_q   <= 7'h01;
						red_ones_q  <= 4'h1;
						red_state_q <= RED_WINDOW;
					end
				end
				RED_WINDOW: begin
					red_pos_q  <= red_pos_q + 7'h01;
					red_ones_q <= red_ones_q + 4'(rx_bit);
					if (rx_bit && red_ones_q == 4'(`T1RAD_RED_CLR_ONES - 1)) begin
						red_state_q <= RED_CLEAR;
					end else if (red_pos_q == 7'(`T1RAD_RED_CLR_WINDOW - 1)) begin
						red_state_q <= RED_ALARM;
					end
				end
				default: begin
					red_state_q <= RED_CLEAR;
				end
			endcase
		end
	end

	always_comb begin
		flags.blue_alarm_flag   = blue_q;
		flags.carrier_loss_flag = red_state_q != RED_CLEAR;
		flags.sync_loss_flag    = ~rx_sync_q.sync;
		if (ctl_q[`T1RAD_CTL_ESF_MODE]) begin
			flags.yellow_alarm_flag = esf_yellow_q;
		end else if (ctl_q[`T1RAD_CTL_YELLOW_MODE_SELECT]) begin
			flags.yellow_alarm_flag = f12_yellow_q;
		end else begin
			flags.yellow_alarm_flag = d4_yellow_q;
		end
	end

	// Sticky events latch each rising flag; a set in the clearing cycle wins.
	always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			flags_last_q <= '0;
			event_q      <= '0;
		end else begin
			flags_last_q <= flags;
			event_q      <= (event_q & ~clear_pulse) | (flags & ~flags_last_q);
		end
	end

	assign IRQ_O = |(event_q & enable_q);

	// Write path: address and data are captured in either order.
	assign S_AXI_AWREADY_O = ~aw_have_q & ~bvalid_q;
	assign S_AXI_WREADY_O  = ~w_have_q & ~bvalid_q;
	assign wr_fire         = aw_have_q & w_have_q & ~bvalid_q;
	assign S_AXI_BVALID_O  = bvalid_q;
	assign S_AXI_BRESP_O   = bresp_q;

	always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			aw_have_q <= 1'b0;
			aw_addr_q <= '0;
			w_have_q  <= 1'b0;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= `T1RAD_RESP_OKAY;
		end else begin
			if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= S_AXI_AWADDR_I;
			end
			if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
				w_have_q <= 1'b1;
				w_data_q <= S_AXI_WDATA_I;
				w_strb_q <= S_AXI_WSTRB_I;
			end
			if (wr_fire) begin
				aw_have_q <= 1'b0;
				w_have_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				case (aw_addr_q)
					ADDR_W'(`T1RAD_EVENT_CLEAR_OFS),
					ADDR_W'(`T1RAD_EVENT_ENABLE_OFS),
					ADDR_W'(`T1RAD_CONTROL_OFS): bresp_q <= `T1RAD_RESP_OKAY;
					default: bresp_q <= `T1RAD_RESP_SLVERR;
				endcase
			end else if (bvalid_q && S_AXI_BREADY_I) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// All fields sit in byte lane 0, so only strobe bit 0 matters.
	always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			ctl_q    <= `T1RAD_CTL_RESET;
			enable_q <= `T1RAD_ENABLE_RESET;
		end else if (wr_fire && w_strb_q[0]) begin
			if (aw_addr_q == ADDR_W'(`T1RAD_EVENT_ENABLE_OFS)) begin
				enable_q <= w_data_q[FW-1:0];
			end
			if (aw_addr_q == ADDR_W'(`T1RAD_CONTROL_OFS)) begin
				ctl_q <= w_data_q[1:0];
			end
		end
	end

	always_comb begin
		clear_pulse = '0;
		if (wr_fire && w_strb_q[0] && aw_addr_q == ADDR_W'(`T1RAD_EVENT_CLEAR_OFS)) begin
			clear_pulse = w_data_q[FW-1:0];
		end
	end

	// Read path: one read at a time, answered one cycle after it is taken.
	assign S_AXI_ARREADY_O = ~rvalid_q;
	assign S_AXI_RVALID_O  = rvalid_q;
	assign S_AXI_RDATA_O   = rdata_q;
	assign S_AXI_RRESP_O   = rresp_q;

	always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= `T1RAD_RESP_OKAY;
		end else if (S_AXI_ARVALID_I && !rvalid_q) begin
			rvalid_q <= 1'b1;
			rresp_q  <= `T1RAD_RESP_OKAY;
			case (S_AXI_ARADDR_I)
				ADDR_W'(`T1RAD_ALARM_STATUS_ONE_OFS): rdata_q <= {28'h000_0000, flags};
				ADDR_W'(`T1RAD_EVENT_STATUS_OFS):     rdata_q <= {28'h000_0000, event_q};
				ADDR_W'(`T1RAD_EVENT_CLEAR_OFS):      rdata_q <= 32'h0000_0000;
				ADDR_W'(`T1RAD_EVENT_ENABLE_OFS):     rdata_q <= {28'h000_0000, enable_q};
				ADDR_W'(`T1RAD_CONTROL_OFS):          rdata_q <= {28'h000_0000, 2'h0, ctl_q};
				default: begin
					rdata_q <= 32'h0000_0000;
					rresp_q <= `T1RAD_RESP_SLVERR;
				end
			endcase
		end else if (rvalid_q && S_AXI_RREADY_I) begin
			rvalid_q <= 1'b0;
		end
	end

endmodule : t1rad_top

// File: rtl/t1rad_regs.svh
`ifndef T1RAD_REGS_SVH
`define T1RAD_REGS_SVH

`define T1RAD_ALARM_STATUS_ONE_OFS  8'h00
`define T1RAD_EVENT_STATUS_OFS      8'h04
`define T1RAD_EVENT_CLEAR_OFS       8'h08
`define T1RAD_EVENT_ENABLE_OFS      8'h0C
`define T1RAD_CONTROL_OFS           8'h10

`define T1RAD_BIT_SYNC_LOSS         0
`define T1RAD_BIT_CARRIER_LOSS      1
`define T1RAD_BIT_YELLOW            2
`define T1RAD_BIT_BLUE              3
`define T1RAD_FLAG_WIDTH            4

`define T1RAD_CTL_YELLOW_MODE_SELECT 0
`define T1RAD_CTL_ESF_MODE          1
`define T1RAD_CTL_RESET             2'h0
`define T1RAD_ENABLE_RESET          4'h0

`define T1RAD_CLK_PERIOD_NS         8
`define T1RAD_BLUE_WINDOW_NS        3000000
`define T1RAD_BLUE_WINDOW_CYC       ((`T1RAD_BLUE_WINDOW_NS + `T1RAD_CLK_PERIOD_NS - 1) / `T1RAD_CLK_PERIOD_NS)
`define T1RAD_BLUE_MAX_ZEROS        5
`define T1RAD_BLUE_CLR_ZEROS        6

`define T1RAD_D4_GROUP              256
`define T1RAD_D4_SET_ZEROS          254
`define T1RAD_ESF_PATTERN           16'h00FF
`define T1RAD_ESF_PATTERNS          16
`define T1RAD_ESF_CLR_MAX           14
`define T1RAD_RED_SET_ZEROS         192
`define T1RAD_RED_CLR_WINDOW        112
`define T1RAD_RED_CLR_ONES          14

`define T1RAD_RESP_OKAY             2'h0
`define T1RAD_RESP_SLVERR           2'h2

`endif

// File: rtl/t1rad_pkg.sv
package t1rad_pkg;

	typedef struct packed {
		logic blue_alarm_flag;
		logic yellow_alarm_flag;
		logic carrier_loss_flag;
		logic sync_loss_flag;
	} t1rad_flags_type;

	typedef struct packed {
		logic data;
		logic strobe;
		logic ch_bit2;
		logic fbit12;
		logic facility_data_link;
		logic sync;
	} t1rad_rx_type;

	typedef enum logic [1:0] {
		RED_CLEAR,
		RED_ALARM,
		RED_WINDOW
	} t1rad_red_state_type;

endpackage : t1rad_pkg

// File: verification/t1rad_assertions.sv
`timescale 1ns/1ps
module t1rad_assertions #(
	parameter int ADDR_W = 8
) (
	input wire logic              REF_CLK_I,
	input wire logic              RESET_N_I,
	input wire logic              RX_SYNC_I,
	input wire logic              S_AXI_AWVALID_I,
	input wire logic              S_AXI_AWREADY_O,
	input wire logic              S_AXI_WVALID_I,
	input wire logic              S_AXI_WREADY_O,
	input wire logic              S_AXI_BVALID_O,
	input wire logic              S_AXI_BREADY_I,
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
	input wire logic              S_AXI_ARVALID_I,
	input wire logic              S_AXI_ARREADY_O,
	input wire logic [31:0]       S_AXI_RDATA_O,
	input wire logic [1:0]        S_AXI_RRESP_O,
	input wire logic              S_AXI_RVALID_O,
	input wire logic              S_AXI_RREADY_I
);
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (!RESET_N_I);
	sequence s_ar_take;
		S_AXI_ARVALID_I && S_AXI_ARREADY_O;
	endsequence
	sequence s_wr_take;
		S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
	endsequence
	sequence s_flag_read;
		s_ar_take ##0 (S_AXI_ARADDR_I == '0);
	endsequence
	a_ar_held_off: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
		else $error("read address accepted while a read answer is pending");
	a_aw_held_off: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
		else $error("write accepted while a write answer is pending");
	a_write_busy: assert property (s_wr_take |=> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
		else $error("write channels ready again before the answer");
	a_write_answer: assert property (s_wr_take |-> ##2 S_AXI_BVALID_O)
		else $error("write answer missing two cycles after acceptance");
	a_write_close: assert property (S_AXI_BVALID_O && S_AXI_BREADY_I |=> !S_AXI_BVALID_O)
		else $error("write answer stayed after its handshake");
	a_read_answer: assert property (s_ar_take |=> S_AXI_RVALID_O)
		else $error("read answer missing one cycle after acceptance");
	a_read_close: assert property (S_AXI_RVALID_O && S_AXI_RREADY_I |=> !S_AXI_RVALID_O)
		else $error("read answer stayed after its handshake");
	a_unmapped_err: assert property (s_ar_take ##0 (S_AXI_ARADDR_I > 'h10) |=>
		S_AXI_RRESP_O == 2'h2 && S_AXI_RDATA_O == 32'h0000_0000)
		else $error("unmapped read not refused with zero data");
	// The flag trails the pin by two clocks, so four stable cycles leave margin before the read.
	a_sync_flag_set: assert property ((!RX_SYNC_I)[*4] ##0 s_flag_read |=> S_AXI_RDATA_O[0])
		else $error("sync loss flag low while framer out of sync");
	a_sync_flag_clr: assert property (RX_SYNC_I[*4] ##0 s_flag_read |=> !S_AXI_RDATA_O[0])
		else $error("sync loss flag high while framer in sync");
endmodule : t1rad_assertions

bind t1rad_top t1rad_assertions #(.ADDR_W(ADDR_W)) u_chk (
	.REF_CLK_I(REF_CLK_I), .RESET_N_I(RESET_N_I), .RX_SYNC_I(RX_SYNC_I),
	.S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
	.S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O),
	.S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I),
	.S_AXI_ARADDR_I(S_AXI_ARADDR_I), .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
	.S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RDATA_O(S_AXI_RDATA_O),
	.S_AXI_RRESP_O(S_AXI_RRESP_O), .S_AXI_RVALID_O(S_AXI_RVALID_O),
	.S_AXI_RREADY_I(S_AXI_RREADY_I)
);

// File: verification/t1rad_line_model.sv
`timescale 1ns/1ps
module t1rad_line_model
	import t1rad_pkg::*;
(
	input  wire logic   clk_i,
	output t1rad_rx_type rx_o
);
	initial rx_o = '0;
	task automatic set_sync(input logic s);
		rx_o.sync <= s;
	endtask : set_sync
	// After the hold time the line shows the inverse, so a stale bit can never pass as fresh.
	task automatic send(input logic d, input logic [1:0] k);
		rx_o.data    <= d;
		rx_o.ch_bit2 <= (k == 2'h1);
		rx_o.fbit12  <= (k == 2'h2);
		rx_o.facility_data_link <= (k == 2'h3);
		repeat (3) @(posedge clk_i);
		rx_o.strobe  <= 1'b1;
		repeat (3) @(posedge clk_i);
		rx_o.strobe  <= 1'b0;
		rx_o.data    <= ~d;
		rx_o.ch_bit2 <= 1'b0;
		rx_o.fbit12  <= 1'b0;
		rx_o.facility_data_link <= 1'b0;
		@(posedge clk_i);
	endtask : send
endmodule : t1rad_line_model

// File: verification/t1rad_top_tb.sv
`timescale 1ns/1ps
module t1rad_top_tb
	import t1rad_pkg::*;
;
	typedef struct packed {
		logic [3:0] m;
		logic [3:0] e;
		logic [1:0] r;
	} t1rad_exp_type;
	logic          clk, rst_n, irq, awvalid, awready, wvalid, wready, bvalid, bready;
	logic          arvalid, arready, rvalid, rready;
	logic [7:0]    awaddr, araddr;
	logic [31:0]   wdata, rdata;
	logic [3:0]    wstrb;
	logic [1:0]    bresp, rresp;
	logic [15:0]   w;
	t1rad_rx_type  rx;
	t1rad_exp_type ex;
	t1rad_exp_type rq[$];
	logic [1:0]    bq[$];
	integer        seed;
	int            failures, check_count, cyc, i;

	initial clk = 1'b0;
	always #4 clk = ~clk;

	// Seven clocks per bit make one blue window exactly one hundred bit times.
	t1rad_top #(.BLUE_WINDOW_CYCLES(700), .ADDR_W(8)) uut (
		.REF_CLK_I(clk), .RESET_N_I(rst_n), .RX_DATA_I(rx.data), .RX_BIT_STROBE_I(rx.strobe),
		.RX_CH_BIT2_I(rx.ch_bit2), .RX_FBIT12_I(rx.fbit12),
		.RX_FACILITY_DATA_LINK_I(rx.facility_data_link),
		.RX_SYNC_I(rx.sync), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
		.S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb),
		.S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
		.S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr),
		.S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
		.S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .IRQ_O(irq)
	);
	t1rad_line_model line (.clk_i(clk), .rx_o(rx));

	task automatic end_of_test();
		if (failures == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
		check_count++;
		if (s !== x) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, x, s);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [3:0] d, input logic [1:0] r);
		logic ta, tw, tb;
		bq.push_back(r);
		@(posedge clk);
		awaddr  <= a;
		wdata   <= 32'(d);
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(negedge clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end while (!tb);
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [3:0] m, input logic [3:0] e,
		input logic [1:0] r);
		logic ta, tv;
		rq.push_back('{m, e, r});
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(negedge clk);
			ta = arvalid && arready;
			tv = rvalid;
			@(posedge clk);
			if (ta) arvalid <= 1'b0;
		end while (!tv);
		rready <= 1'b0;
	endtask : rd

	task automatic fl(input logic [3:0] m, input logic [3:0] e);
		rd(8'h00, m, e, 2'h0);
	endtask : fl

	task automatic sw(input logic [15:0] v);
		for (int k = 15; k >= 0; k--) line.send(v[k], 2'h3);
	endtask : sw

	task automatic irq_is(input logic v);
		@(negedge clk);
		chk("irq", 32'(irq), 32'(v));
	endtask : irq_is

	always @(posedge clk) begin
		if (rvalid && rready) begin
			ex = rq.pop_front();
			chk("rdata", rdata & 32'(ex.m), 32'(ex.e));
			chk("rresp", 32'(rresp), 32'(ex.r));
		end
		if (bvalid && bready) chk("bresp", 32'(bresp), 32'(bq.pop_front()));
	end

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			failures++;
			end_of_test();
		end
	end

	initial begin
		{awvalid, wvalid, bready, arvalid, rready, rst_n} = '0;
		{awaddr, araddr} = '0;
		wdata = 32'h0000_0000;
		wstrb = 4'hF;
		seed = 9;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		fl(4'hF, 4'h1);
		rd(8'h08, 4'hF, 4'h0, 2'h0);
		rd(8'h0C, 4'hF, 4'h0, 2'h0);
		rd(8'h10, 4'hF, 4'h0, 2'h0);
		rd(8'h40, 4'hF, 4'h0, 2'h2);
		wr(8'h04, 4'hF, 2'h2);
		for (i = 0; i < 191; i++) line.send(1'b0, 2'h0);
		fl(4'h2, 4'h0);
		line.send(1'b0, 2'h0);
		fl(4'h2, 4'h2);
		for (i = 0; i < 112; i++) line.send(i % 9 == 0, 2'h0);
		fl(4'h2, 4'h2);
		for (i = 0; i < 14; i++) line.send(1'b1, 2'h0);
		fl(4'h2, 4'h0);
		for (i = 0; i < 300; i++) line.send(i % 20 != 0, 2'h0);
		fl(4'h9, 4'h9);
		for (i = 0; i < 300; i++) line.send(i % 16 != 0, 2'h0);
		fl(4'h8, 4'h0);
		for (i = 0; i < 256; i++) line.send(i == 0 || i == 100, 2'h1);
		fl(4'h4, 4'h4);
		for (i = 0; i < 256; i++) line.send(i < 3, 2'h1);
		fl(4'h4, 4'h0);
		wr(8'h10, 4'h1, 2'h0);
		for (i = 0; i < 6; i++) begin
			line.send(1'(6'b001101 >> i), 2'h2);
			fl(4'h4, (i == 3 || i == 4) ? 4'h4 : 4'h0);
		end
		wr(8'h10, 4'h2, 2'h0);
		for (i = 0; i < 16; i++) begin
			sw(16'h00FF);
			fl(4'h4, (i == 15) ? 4'h4 : 4'h0);
		end
		for (i = 0; i < 2; i++) begin
			w = 16'($random(seed));
			if (w == 16'h00FF) w = 16'h0F0F;
			sw(w);
			fl(4'h4, (i == 0) ? 4'h4 : 4'h0);
		end
		rd(8'h04, 4'hE, 4'hE, 2'h0);
		irq_is(1'b0);
		wr(8'h0C, 4'h2, 2'h0);
		irq_is(1'b1);
		wr(8'h08, 4'hF, 2'h0);
		rd(8'h04, 4'h7, 4'h0, 2'h0);
		irq_is(1'b0);
		line.set_sync(1'b1);
		repeat (4) @(posedge clk);
		fl(4'h1, 4'h0);
		line.set_sync(1'b0);
		repeat (4) @(posedge clk);
		fl(4'h1, 4'h1);
		wr(8'h0C, 4'h1, 2'h0);
		irq_is(1'b1);
		wr(8'h0C, 4'h0, 2'h0);
		irq_is(1'b0);
		// Without byte lane 0 the enable write must leave the register untouched.
		@(posedge clk);
		wstrb <= 4'hE;
		wr(8'h0C, 4'h1, 2'h0);
		irq_is(1'b0);
		rd(8'h0C, 4'hF, 4'h0, 2'h0);
		end_of_test();
	end
endmodule : t1rad_top_tb
